/* inc/dglp_pkg.sv */
// Package of register indices, field layouts, reset values and codes for the gain/pattern bank.
package dglp_pkg;

  // Register indices; the AHB byte address of each register is four times its index.
  localparam logic [7:0]  DGLP_IDX_BAND_ONE_GAIN = 8'h14;
  localparam logic [7:0]  DGLP_IDX_BAND_TWO_GAIN = 8'h16;
  localparam logic [7:0]  DGLP_IDX_LATENCY_ALIGN = 8'h1E;
  localparam logic [7:0]  DGLP_IDX_WIDEBAND_GAIN = 8'h1F;
  localparam logic [7:0]  DGLP_IDX_PATTERN_A_LOW = 8'h33;
  localparam logic [7:0]  DGLP_IDX_PATTERN_A_HIGH = 8'h34;
  localparam logic [7:0]  DGLP_IDX_PATTERN_B_LOW = 8'h35;
  localparam logic [7:0]  DGLP_IDX_PATTERN_B_HIGH = 8'h36;
  localparam logic [7:0]  DGLP_IDX_PATTERN_SELECT = 8'h37;

  // Byte-address layout: word index in haddr[9:2], haddr[1:0] must be zero.
  localparam int          DGLP_IDX_LSB           = 2;
  localparam int          DGLP_IDX_MSB           = 9;

  // Field positions.
  localparam int          DGLP_DOUBLE_BIT        = 0;
  localparam int          DGLP_LAT_LSB           = 4;
  localparam int          DGLP_LAT_W             = 3;
  localparam int          DGLP_PAT_SEL_W         = 4;
  localparam int          DGLP_BYTE_W            = 8;

  // Reset values.
  localparam logic        DGLP_DOUBLE_RESET      = 1'b0;
  localparam logic [2:0]  DGLP_LAT_RESET         = 3'h0;
  localparam logic [15:0] DGLP_PATTERN_RESET     = 16'h0000;
  localparam logic [3:0]  DGLP_PAT_SEL_RESET     = 4'h0;

  // Test-pattern select codes that consume the user patterns.
  localparam logic [3:0]  DGLP_PAT_SINGLE        = 4'h6;
  localparam logic [3:0]  DGLP_PAT_DOUBLE        = 4'h7;

  // Datapath defaults.
  localparam int          DGLP_SAMPLE_W          = 16;
  localparam int          DGLP_PATTERN_W         = 16;
  localparam int          DGLP_NUM_PATHS         = 3;

  // AHB-Lite encodings.
  localparam logic [1:0]  DGLP_HTRANS_NONSEQ     = 2'h2;
  localparam logic        DGLP_HRESP_OKAY        = 1'b0;

endpackage : dglp_pkg

/* inc/dglp_gain_if.sv */
// Interface between the register bank and one saturating doubler.
`timescale 1ns/1ns
interface dglp_gain_if #(
  parameter int W = 16
);
  logic signed [W-1:0] sample_in;
  logic                double_en;
  logic signed [W-1:0] sample_out;

  modport scaler (input sample_in, input double_en, output sample_out);
  modport user   (output sample_in, output double_en, input sample_out);
endinterface : dglp_gain_if

/* rtl/dglp_gain_sat.sv */
// Optional times-two gain stage with saturation for one sample path.
`timescale 1ns/1ns
module dglp_gain_sat #(
  parameter int W = 16
) (
  dglp_gain_if.scaler gp  // Sample, enable and scaled result.
);
  logic signed [W-1:0] max_code;
  logic signed [W-1:0] min_code;
  logic                overflow;

  assign max_code = {1'b0, {(W-1){1'b1}}};
  assign min_code = {1'b1, {(W-1){1'b0}}};
  // Doubling overflows exactly when the two top bits differ.
  assign overflow = gp.sample_in[W-1] ^ gp.sample_in[W-2];

  always_comb begin
    if (!gp.double_en) begin
      gp.sample_out = gp.sample_in;
    end else if (overflow) begin
      gp.sample_out = gp.sample_in[W-1] ? min_code : max_code;
    end else begin
      gp.sample_out = {gp.sample_in[W-2:0], 1'b0};
    end
  end
endmodule : dglp_gain_sat

/* rtl/dglp_regs.sv */
// Gain, latency-alignment and user-pattern register bank with its AHB-Lite slave.
`timescale 1ns/1ns
//
// Function
// - Gain bit 0 of each narrow-band converter doubles that converter's output.
// - Narrow-band gain bits never scale the wide-bandwidth filter path.
// - Wide-band gain bit 0 doubles the wide-bandwidth filter output.
// - Wide-band gain bit leaves both narrow-band outputs untouched.
// - Three-bit latency alignment code in bits 6:4, reset to zero.
// - Two 16-bit user patterns in four bytes at 33h..36h, reset to zero.
// - Single mode sends pattern A; double mode alternates pattern A and B.
module dglp_regs
  import dglp_pkg::*;
#(
  parameter int SAMPLE_W  = DGLP_SAMPLE_W,
  parameter int PATTERN_W = DGLP_PATTERN_W
) (
  input  wire logic                       clk,                // 50 MHz clock.
  input  wire logic                       rst_b,              // Synchronous reset, active low.
  input  wire logic                       hsel,               // AHB slave select.
  input  wire logic [31:0]                haddr,              // AHB byte address.
  input  wire logic [1:0]                 htrans,             // AHB transfer type.
  input  wire logic                       hwrite,             // AHB write when high.
  input  wire logic [2:0]                 hsize,              // AHB transfer size.
  input  wire logic [31:0]                hwdata,             // AHB write data.
  input  wire logic                       hready,             // AHB bus ready.
  output logic                            hreadyout,          // AHB slave ready.
  output logic                            hresp,              // AHB response, always OKAY.
  output logic [31:0]                     hrdata,             // AHB read data.
  input  wire logic signed [SAMPLE_W-1:0] band_one_in,        // First converter sample.
  input  wire logic signed [SAMPLE_W-1:0] band_two_in,        // Second converter sample.
  input  wire logic signed [SAMPLE_W-1:0] wideband_in,        // Wide filter sample.
  output logic signed [SAMPLE_W-1:0]      band_one_out,       // First converter result.
  output logic signed [SAMPLE_W-1:0]      band_two_out,       // Second converter result.
  output logic signed [SAMPLE_W-1:0]      wideband_out,       // Wide filter result.
  output logic [2:0]                      latency_align_code, // Alignment code to the filter.
  output logic [PATTERN_W-1:0]            pattern_out,        // Current user pattern word.
  output logic                            pattern_valid       // Pattern mode is active.
);

  typedef struct packed {
    logic                       wr_pend;
    logic [7:0]                 wr_idx;
    logic                       band_one_double_enable;
    logic                       band_two_double_enable;
    logic                       wideband_double_enable;
    logic [2:0]                 latency_align_code;
    logic [PATTERN_W-1:0]       user_pattern_a;
    logic [PATTERN_W-1:0]       user_pattern_b;
    logic [3:0]                 pattern_select;
    logic                       pattern_phase;
    logic [31:0]                hrdata;
    logic                       hreadyout;
    logic                       hresp;
    logic signed [SAMPLE_W-1:0] band_one_out;
    logic signed [SAMPLE_W-1:0] band_two_out;
    logic signed [SAMPLE_W-1:0] wideband_out;
    logic [PATTERN_W-1:0]       pattern_out;
    logic                       pattern_valid;
  } dglp_state_type;

  dglp_state_type s_reg;
  dglp_state_type s_next;

  logic signed [SAMPLE_W-1:0] path_in     [DGLP_NUM_PATHS];
  logic                       path_en     [DGLP_NUM_PATHS];
  logic signed [SAMPLE_W-1:0] path_scaled [DGLP_NUM_PATHS];
  logic [7:0]                 addr_idx;
  logic                       addr_aligned;
  logic                       accept;

  // Each enable is wired to its own path only, so no gain bit reaches another path.
  assign path_in[0] = band_one_in;
  assign path_in[1] = band_two_in;
  assign path_in[2] = wideband_in;
  assign path_en[0] = s_reg.band_one_double_enable;
  assign path_en[1] = s_reg.band_two_double_enable;
  assign path_en[2] = s_reg.wideband_double_enable;

  generate
    for (genvar g = 0; g < DGLP_NUM_PATHS; g++) begin : g_path
      dglp_gain_if #(.W(SAMPLE_W)) gi ();
      assign gi.sample_in = path_in[g];
      assign gi.double_en = path_en[g];
      assign path_scaled[g] = gi.sample_out;
      dglp_gain_sat #(.W(SAMPLE_W)) u_sat (
        .gp (gi)
      );
    end
  endgenerate

  assign addr_idx     = haddr[DGLP_IDX_MSB:DGLP_IDX_LSB];
  assign addr_aligned = (haddr[DGLP_IDX_LSB-1:0] == 2'h0) && (haddr[31:DGLP_IDX_MSB+1] == '0);
  assign accept       = hsel && hready && (htrans == DGLP_HTRANS_NONSEQ || htrans == 2'h3);

  function automatic logic is_mapped(input logic [7:0] idx);
    logic hit;
    hit = 1'b0;
    if (idx == DGLP_IDX_BAND_ONE_GAIN) begin
      hit = 1'b1;
    end else if (idx == DGLP_IDX_BAND_TWO_GAIN) begin
      hit = 1'b1;
    end else if (idx == DGLP_IDX_LATENCY_ALIGN) begin
      hit = 1'b1;
    end else if (idx == DGLP_IDX_WIDEBAND_GAIN) begin
      hit = 1'b1;
    end else if (idx >= DGLP_IDX_PATTERN_A_LOW && idx <= DGLP_IDX_PATTERN_SELECT) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_mapped

  // Reserved bits are not stored, so they always read back as zero.
  function automatic logic [31:0] read_word(input dglp_state_type s, input logic [7:0] idx);
    logic [31:0] w;
    w = 32'h00000000;
    if (idx == DGLP_IDX_BAND_ONE_GAIN) begin
      w[DGLP_DOUBLE_BIT] = s.band_one_double_enable;
    end else if (idx == DGLP_IDX_BAND_TWO_GAIN) begin
      w[DGLP_DOUBLE_BIT] = s.band_two_double_enable;
    end else if (idx == DGLP_IDX_LATENCY_ALIGN) begin
      w[DGLP_LAT_LSB +: DGLP_LAT_W] = s.latency_align_code;
    end else if (idx == DGLP_IDX_WIDEBAND_GAIN) begin
      w[DGLP_DOUBLE_BIT] = s.wideband_double_enable;
    end else if (idx == DGLP_IDX_PATTERN_A_LOW) begin
      w[DGLP_BYTE_W-1:0] = s.user_pattern_a[7:0];
    end else if (idx == DGLP_IDX_PATTERN_A_HIGH) begin
      w[DGLP_BYTE_W-1:0] = s.user_pattern_a[15:8];
    end else if (idx == DGLP_IDX_PATTERN_B_LOW) begin
      w[DGLP_BYTE_W-1:0] = s.user_pattern_b[7:0];
    end else if (idx == DGLP_IDX_PATTERN_B_HIGH) begin
      w[DGLP_BYTE_W-1:0] = s.user_pattern_b[15:8];
    end else if (idx == DGLP_IDX_PATTERN_SELECT) begin
      w[DGLP_PAT_SEL_W-1:0] = s.pattern_select;
    end
    return w;
  endfunction : read_word

  always_comb begin
    s_next = s_reg;

    // A write lands at the end of its data phase, when hwdata is valid.
    if (s_reg.wr_pend) begin
      if (s_reg.wr_idx == DGLP_IDX_BAND_ONE_GAIN) begin
        s_next.band_one_double_enable = hwdata[DGLP_DOUBLE_BIT];
      end else if (s_reg.wr_idx == DGLP_IDX_BAND_TWO_GAIN) begin
        s_next.band_two_double_enable = hwdata[DGLP_DOUBLE_BIT];
      end else if (s_reg.wr_idx == DGLP_IDX_LATENCY_ALIGN) begin
        s_next.latency_align_code = hwdata[DGLP_LAT_LSB +: DGLP_LAT_W];
      end else if (s_reg.wr_idx == DGLP_IDX_WIDEBAND_GAIN) begin
        s_next.wideband_double_enable = hwdata[DGLP_DOUBLE_BIT];
      end else if (s_reg.wr_idx == DGLP_IDX_PATTERN_A_LOW) begin
        s_next.user_pattern_a[7:0] = hwdata[DGLP_BYTE_W-1:0];
      end else if (s_reg.wr_idx == DGLP_IDX_PATTERN_A_HIGH) begin
        s_next.user_pattern_a[15:8] = hwdata[DGLP_BYTE_W-1:0];
      end else if (s_reg.wr_idx == DGLP_IDX_PATTERN_B_LOW) begin
        s_next.user_pattern_b[7:0] = hwdata[DGLP_BYTE_W-1:0];
      end else if (s_reg.wr_idx == DGLP_IDX_PATTERN_B_HIGH) begin
        s_next.user_pattern_b[15:8] = hwdata[DGLP_BYTE_W-1:0];
      end else if (s_reg.wr_idx == DGLP_IDX_PATTERN_SELECT) begin
        s_next.pattern_select = hwdata[DGLP_PAT_SEL_W-1:0];
      end
    end

    // Address phase. Read data are taken from the post-write values, so a read
    // right behind a write to the same register sees the new contents.
    s_next.wr_pend   = 1'b0;
    s_next.hreadyout = 1'b1;
    s_next.hresp     = DGLP_HRESP_OKAY;
    if (accept) begin
      s_next.wr_idx = addr_idx;
      if (hwrite) begin
        s_next.wr_pend = addr_aligned && is_mapped(addr_idx);
      end else if (addr_aligned) begin
        s_next.hrdata = read_word(s_next, addr_idx);
      end else begin
        s_next.hrdata = 32'h00000000;
      end
    end

    // Pattern generator: phase only runs in double mode so it always starts on A.
    if (s_reg.pattern_select == DGLP_PAT_SINGLE) begin
      s_next.pattern_out   = s_reg.user_pattern_a;
      s_next.pattern_valid = 1'b1;
      s_next.pattern_phase = 1'b0;
    end else if (s_reg.pattern_select == DGLP_PAT_DOUBLE) begin
      s_next.pattern_out   = s_reg.pattern_phase ? s_reg.user_pattern_b
                                                 : s_reg.user_pattern_a;
      s_next.pattern_valid = 1'b1;
      s_next.pattern_phase = ~s_reg.pattern_phase;
    end else begin
      s_next.pattern_out   = '0;
      s_next.pattern_valid = 1'b0;
      s_next.pattern_phase = 1'b0;
    end

    s_next.band_one_out = path_scaled[0];
    s_next.band_two_out = path_scaled[1];
    s_next.wideband_out = path_scaled[2];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg.wr_pend                <= 1'b0;
      s_reg.wr_idx                 <= 8'h00;
      s_reg.band_one_double_enable <= DGLP_DOUBLE_RESET;
      s_reg.band_two_double_enable <= DGLP_DOUBLE_RESET;
      s_reg.wideband_double_enable <= DGLP_DOUBLE_RESET;
      s_reg.latency_align_code     <= DGLP_LAT_RESET;
      s_reg.user_pattern_a         <= DGLP_PATTERN_RESET;
      s_reg.user_pattern_b         <= DGLP_PATTERN_RESET;
      s_reg.pattern_select         <= DGLP_PAT_SEL_RESET;
      s_reg.pattern_phase          <= 1'b0;
      s_reg.hrdata                 <= 32'h00000000;
      s_reg.hreadyout              <= 1'b1;
      s_reg.hresp                  <= DGLP_HRESP_OKAY;
      s_reg.band_one_out           <= '0;
      s_reg.band_two_out           <= '0;
      s_reg.wideband_out           <= '0;
      s_reg.pattern_out            <= '0;
      s_reg.pattern_valid          <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout          = s_reg.hreadyout;
  assign hresp              = s_reg.hresp;
  assign hrdata             = s_reg.hrdata;
  assign band_one_out       = s_reg.band_one_out;
  assign band_two_out       = s_reg.band_two_out;
  assign wideband_out       = s_reg.wideband_out;
  assign latency_align_code = s_reg.latency_align_code;
  assign pattern_out        = s_reg.pattern_out;
  assign pattern_valid      = s_reg.pattern_valid;

endmodule : dglp_regs

/* test/dglp_regs_asserts.sv */
// Concurrent checks on the bus and datapath ports of the gain and pattern register bank.
`timescale 1ns/1ns
module dglp_regs_asserts
  import dglp_pkg::*;
#(
  parameter int SAMPLE_W  = DGLP_SAMPLE_W,
  parameter int PATTERN_W = DGLP_PATTERN_W
) (
  input wire logic                       clk,                // Clock.
  input wire logic                       rst_b,              // Reset, active low.
  input wire logic                       hsel,               // Select.
  input wire logic [31:0]                haddr,              // Address.
  input wire logic [1:0]                 htrans,             // Transfer type.
  input wire logic                       hwrite,             // Write flag.
  input wire logic [2:0]                 hsize,              // Size.
  input wire logic [31:0]                hwdata,             // Write data.
  input wire logic                       hready,             // Bus ready.
  input wire logic                       hreadyout,          // Slave ready.
  input wire logic                       hresp,              // Response.
  input wire logic [31:0]                hrdata,             // Read data.
  input wire logic signed [SAMPLE_W-1:0] band_one_in,        // First sample in.
  input wire logic signed [SAMPLE_W-1:0] band_two_in,        // Second sample in.
  input wire logic signed [SAMPLE_W-1:0] wideband_in,        // Wide sample in.
  input wire logic signed [SAMPLE_W-1:0] band_one_out,       // First result.
  input wire logic signed [SAMPLE_W-1:0] band_two_out,       // Second result.
  input wire logic signed [SAMPLE_W-1:0] wideband_out,       // Wide result.
  input wire logic [2:0]                 latency_align_code, // Alignment code.
  input wire logic [PATTERN_W-1:0]       pattern_out,        // Pattern word.
  input wire logic                       pattern_valid       // Pattern active.
);
  logic take;
  assign take = hsel & hready & htrans[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // The enables are internal, so each result may be either the plain or the doubled sample.
  function automatic logic signed [SAMPLE_W-1:0] dbl(input logic signed [SAMPLE_W-1:0] x);
    logic signed [SAMPLE_W:0] y;
    y = {x, 1'b0};
    if (y[SAMPLE_W] != y[SAMPLE_W-1]) return y[SAMPLE_W] ? {1'b1, {SAMPLE_W-1{1'b0}}} : {1'b0, {SAMPLE_W-1{1'b1}}};
    return y[SAMPLE_W-1:0];
  endfunction : dbl
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("Slave inserted a wait state.");
  property p_okay; hresp == DGLP_HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("Slave response not okay.");
  property p_one; band_one_out == $past(band_one_in) || band_one_out == dbl($past(band_one_in)); endproperty
  a_one: assert property (p_one) else $error("First result not plain or doubled.");
  property p_two; band_two_out == $past(band_two_in) || band_two_out == dbl($past(band_two_in)); endproperty
  a_two: assert property (p_two) else $error("Second result not plain or doubled.");
  property p_wide; wideband_out == $past(wideband_in) || wideband_out == dbl($past(wideband_in)); endproperty
  a_wide: assert property (p_wide) else $error("Wide result not plain or doubled.");
  property p_lat; $changed(latency_align_code) |-> $past(take & hwrite, 2) && $past(haddr[9:2], 2) == DGLP_IDX_LATENCY_ALIGN; endproperty
  a_lat: assert property (p_lat) else $error("Alignment code moved without a write.");
  property p_rdata; $changed(hrdata) |-> $past(take & ~hwrite); endproperty
  a_rdata: assert property (p_rdata) else $error("Read data moved without a read.");
  property p_rhigh; hrdata[31:8] == 24'h000000; endproperty
  a_rhigh: assert property (p_rhigh) else $error("Read data above the byte not zero.");
  property p_pat; !pattern_valid |-> pattern_out == '0; endproperty
  a_pat: assert property (p_pat) else $error("Pattern word outside pattern mode.");
endmodule : dglp_regs_asserts
bind dglp_regs dglp_regs_asserts #(.SAMPLE_W(SAMPLE_W), .PATTERN_W(PATTERN_W)) dglp_regs_asserts_inst (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .band_one_in(band_one_in), .band_two_in(band_two_in), .wideband_in(wideband_in),
  .band_one_out(band_one_out), .band_two_out(band_two_out), .wideband_out(wideband_out),
  .latency_align_code(latency_align_code), .pattern_out(pattern_out), .pattern_valid(pattern_valid));

/* test/dglp_regs_tb_top.sv */
// Self-checking testbench of the gain, latency and pattern register bank.
`timescale 1ns/1ns
module dglp_regs_tb_top
  import dglp_pkg::*;
;
  logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, pattern_valid;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, latency_align_code;
  logic signed [15:0] band_one_in, band_two_in, wideband_in, band_one_out, band_two_out, wideband_out;
  logic [15:0] pattern_out;
  int num_errors = 0;
  int n_compared = 0;
  localparam logic [7:0] IDX [9] = '{8'h14, 8'h16, 8'h1E, 8'h1F, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
  localparam logic [7:0] MSK [9] = '{8'h01, 8'h01, 8'h70, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
  assign hready = hreadyout;
  dglp_regs dglp_regs_inst (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .band_one_in(band_one_in), .band_two_in(band_two_in),
    .wideband_in(wideband_in), .band_one_out(band_one_out), .band_two_out(band_two_out),
    .wideband_out(wideband_out), .latency_align_code(latency_align_code),
    .pattern_out(pattern_out), .pattern_valid(pattern_valid));
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1);
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= DGLP_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  // Write and read of one register back to back: the read address phase overlaps the write data.
  task automatic wr_rd(input logic [7:0] idx, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= DGLP_HTRANS_NONSEQ;
    hwrite <= 1'b1;
    wait_rdy();
    hwrite <= 1'b0;
    hwdata <= d;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    rd = hrdata;
  endtask : wr_rd
  task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, {22'h0, idx, 2'h0}, d, rd);
  endtask : wreg
  task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask : rreg
  // Doubling saturates at the extreme codes rather than wrapping.
  function automatic logic [31:0] expect_out(input logic signed [15:0] v, input logic en);
    if (!en) return {16'h0, v};
    if (v > 16'sh3FFF) return 32'h00007FFF;
    if (v < -16'sh4000) return 32'h00008000;
    return {16'h0, v <<< 1};
  endfunction : expect_out
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  initial begin : main
    logic [31:0] d, pa, pb;
    logic signed [15:0] x;
    logic [7:0] codes [4];
    codes = '{8'h10, 8'h20, 8'h40, 8'h50};
    {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {band_one_in, band_two_in, wideband_in} = '0;
    void'($urandom(9893));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    foreach (IDX[i]) rreg({22'h0, IDX[i], 2'h0}, 32'h0);
    foreach (IDX[i]) begin
      d = $urandom;
      wreg(IDX[i], d);
      rreg({22'h0, IDX[i], 2'h0}, {24'h0, d[7:0] & MSK[i]});
    end
    d = $urandom;
    wr_rd(8'h33, d, pb);
    check(pb, {24'h0, d[7:0]});
    wr_rd(8'h1E, 32'h50, pb);
    check(pb, 32'h50);
    wreg(8'h14, 32'h1);
    bus(1'b1, 32'h51, 32'h0, d);
    bus(1'b1, 32'h450, 32'h0, d);
    wreg(8'h40, 32'hFF);
    rreg(32'h50, 32'h1);
    rreg(32'h51, 32'h0);
    rreg(32'h450, 32'h0);
    rreg(32'h100, 32'h0);
    foreach (codes[i]) begin
      wreg(8'h1E, {24'h0, codes[i]});
      #1 check({29'h0, latency_align_code}, {29'h0, codes[i][6:4]});
    end
    for (int m = 0; m < 8; m++) begin
      wreg(8'h14, m & 1);
      wreg(8'h16, (m >> 1) & 1);
      wreg(8'h1F, (m >> 2) & 1);
      for (int k = 0; k < 6; k++) begin
        x = k == 0 ? 16'h4000 : k == 1 ? 16'hBFFF : k == 2 ? 16'h3FFF : 16'($urandom);
        @(posedge clk);
        band_one_in <= x;
        band_two_in <= ~x;
        wideband_in <= x ^ 16'h5555;
        @(posedge clk);
        #1 check({16'h0, band_one_out}, expect_out(x, m[0]));
        check({16'h0, band_two_out}, expect_out(~x, m[1]));
        check({16'h0, wideband_out}, expect_out(x ^ 16'h5555, m[2]));
      end
    end
    pa = $urandom;
    pb = $urandom;
    wreg(8'h33, pa[7:0]);
    wreg(8'h34, pa[15:8]);
    wreg(8'h35, pb[7:0]);
    wreg(8'h36, pb[15:8]);
    wreg(8'h37, DGLP_PAT_SINGLE);
    repeat (3) begin
      @(posedge clk);
      #1 check({pattern_valid, pattern_out}, {1'b1, pa[15:0]});
    end
    wreg(8'h37, DGLP_PAT_DOUBLE);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1 check({pattern_valid, pattern_out}, {1'b1, i[0] ? pb[15:0] : pa[15:0]});
    end
    wreg(8'h37, 32'h0);
    @(posedge clk);
    #1 check({pattern_valid, pattern_out}, 32'h0);
    close_out();
  end
endmodule : dglp_regs_tb_top
